// ### hw/rd_engine_pkg.sv
// Purpose: Shared constants and carrier types for the status and redirected read engine.
// Assumes: A slot layer below turns bus time slots into one-cycle strobes at 40 MHz.
// Notes: Constant names are used by the engine and by the verification side.
//
// Notes on behaviour
// - Command AAh, then address low, high.
// - Status bytes until page end, then CRC.
// - First status CRC covers command, address, bytes.
// - Status page ends at low digit 7/F.
// - Later status CRCs cover only page bytes.
// - After last status CRC, send ones.
// - Reset pulse aborts status read to idle.
// - Command A5h, then address low, high.
// - Redirection byte, CRC over command, address, byte.
// - Stream data to page end, then CRC.
// - Page CRC covers only bytes sent from page.
// - Next redirection byte with CRC of it alone.
// - Later pages stream from first byte onward.
// - After last data CRC, send ones.
// - Reset pulse ends extended read, drops output.
// - All bits travel least significant first.
// - Address above 7FFh loses top five bits.
// - Unimplemented status locations read FFh.
// - Redirection byte of page n at 100h+n.
package rd_engine_pkg;

	// -------------------------------------------------------------------
	// Commands, address space and CRC
	// -------------------------------------------------------------------
	localparam int ADDR_W = 11;
	localparam logic [7:0] CMD_READ_STATUS = 8'haa;
	localparam logic [7:0] CMD_EXT_READ = 8'ha5;
	localparam logic [ADDR_W-1:0] ADDR_LAST = 11'h7ff;
	localparam logic [ADDR_W-1:0] REDIR_BASE = 11'h100;
	localparam logic [ADDR_W-1:0] REDIR_END = 11'h13f;
	localparam logic [ADDR_W-1:0] WP_PAGE_BASE = 11'h000;
	localparam logic [ADDR_W-1:0] WP_REDIR_BASE = 11'h020;
	localparam logic [ADDR_W-1:0] USED_MAP_BASE = 11'h040;
	localparam logic [2:0] STATUS_PAGE_LAST = 3'h7;
	localparam logic [4:0] DATA_PAGE_LAST = 5'h1f;
	localparam logic [7:0] BLANK_BYTE = 8'hff;
	localparam logic [15:0] CRC_POLY_REFL = 16'ha001;
	localparam logic [15:0] CRC_CLEAR = 16'h0000;
	localparam logic [15:0] CRC_OUT_XOR = 16'h0000;
	localparam logic [4:0] BITS_BYTE = 5'h08;
	localparam logic [4:0] BITS_ADDR = 5'h10;
	localparam logic [4:0] BITS_CRC = 5'h10;

	// -------------------------------------------------------------------
	// Carrier types
	// -------------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic wbit;
		logic rd;
	} slot_t;

	typedef struct packed {
		logic en;
		logic status;
		logic [ADDR_W-1:0] addr;
	} mem_req_t;

	typedef enum logic [2:0] {
		ST_CMD, ST_ADDR, ST_FETCH, ST_BYTE, ST_CRC, ST_ONES, ST_IGNORE
	} eng_state_t;

endpackage

// ### hw/rd_engine.sv
// Purpose: Read status and extended read sequencer of a single-wire add-only memory.
// Assumes: Strobes are synchronous one-cycle pulses, at least three cycles apart.
// Notes: Memory answers combinationally in the cycle its request is raised.
`timescale 1ns/1ps

module rd_engine (
	input wire logic clk,
	input wire logic reset,
	input wire logic bus_rst,
	input wire rd_engine_pkg::slot_t slot,
	input wire logic [7:0] mem_rdata,
	output rd_engine_pkg::mem_req_t mem_req,
	output logic tx_bit,
	output logic busy
);
	import rd_engine_pkg::*;

	eng_state_t state_r;
	logic ext_r;
	logic redir_r;
	logic [ADDR_W-1:0] addr_r;
	logic [15:0] rx_r;
	logic [15:0] tx_r;
	logic [15:0] crc_r;
	logic [4:0] cnt_r;
	logic [7:0] fetch_byte;
	logic [ADDR_W-1:0] fetch_addr;
	logic last_bit;
	logic page_end;
	logic [15:0] rx_nxt;
	logic crc_in;

	// -------------------------------------------------------------------
	// CRC and status map helpers
	// -------------------------------------------------------------------
	// One reflected CRC step; data enters least significant bit first.
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
		logic [15:0] r;
		r = c >> 1;
		if (c[0] ^ b) begin
			r = r ^ CRC_POLY_REFL;
		end
		return r;
	endfunction

	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = crc_step(r, d[i]);
		end
		return r;
	endfunction

	// Status locations outside the implemented windows hold nothing.
	function automatic logic status_impl(input logic [ADDR_W-1:0] a);
		return (a[ADDR_W-1:3] == WP_PAGE_BASE[ADDR_W-1:3]) ||
			(a[ADDR_W-1:3] == WP_REDIR_BASE[ADDR_W-1:3]) ||
			(a[ADDR_W-1:3] == USED_MAP_BASE[ADDR_W-1:3]) ||
			(a >= REDIR_BASE && a <= REDIR_END);
	endfunction

	// -------------------------------------------------------------------
	// Fetch address and byte
	// -------------------------------------------------------------------
	// Redirection bytes live in status space, one per 32-byte data page.
	always_comb begin
		if (redir_r) begin
			fetch_addr = REDIR_BASE + {5'h00, addr_r[10:5]};
		end else begin
			fetch_addr = addr_r;
		end
		if ((!ext_r || redir_r) && !status_impl(fetch_addr)) begin
			fetch_byte = BLANK_BYTE;
		end else begin
			fetch_byte = mem_rdata;
		end
	end

	assign mem_req.en = (state_r == ST_FETCH);
	assign mem_req.status = !ext_r || redir_r;
	assign mem_req.addr = fetch_addr;
	assign last_bit = slot.rd && (cnt_r == 5'h01);
	assign page_end = ext_r ? (addr_r[4:0] == DATA_PAGE_LAST) : (addr_r[2:0] == STATUS_PAGE_LAST);
	assign rx_nxt = {slot.wbit, rx_r[15:1]};
	assign busy = (state_r != ST_CMD) && (state_r != ST_IGNORE);

	// Address bits above the implemented range reach the CRC as zeros. A master
	// that sent a too-high address then sees a CRC that disagrees with its own,
	// which is the only warning it gets.
	always_comb begin
		crc_in = slot.wbit;
		if (state_r == ST_ADDR && cnt_r <= BITS_ADDR - 5'(ADDR_W)) begin
			crc_in = 1'b0;
		end
	end

	// -------------------------------------------------------------------
	// Sequencer
	// -------------------------------------------------------------------
	// A reset pulse beats every other event so no pending byte or CRC survives.
	always_ff @(posedge clk) begin
		if (reset || bus_rst) begin
			state_r <= ST_CMD;
			cnt_r <= BITS_BYTE;
			ext_r <= 1'b0;
			redir_r <= 1'b0;
			addr_r <= '0;
			rx_r <= '0;
			tx_r <= '1;
		end else begin
			unique case (state_r)
				ST_CMD: begin
					if (slot.wr) begin
						rx_r <= rx_nxt;
						cnt_r <= cnt_r - 5'h01;
						if (cnt_r == 5'h01) begin
							cnt_r <= BITS_ADDR;
							ext_r <= (rx_nxt[15:8] == CMD_EXT_READ);
							redir_r <= (rx_nxt[15:8] == CMD_EXT_READ);
							if (rx_nxt[15:8] == CMD_READ_STATUS || rx_nxt[15:8] == CMD_EXT_READ) begin
								state_r <= ST_ADDR;
							end else begin
								state_r <= ST_IGNORE;
							end
						end
					end
				end
				ST_ADDR: begin
					if (slot.wr) begin
						rx_r <= rx_nxt;
						cnt_r <= cnt_r - 5'h01;
						if (cnt_r == 5'h01) begin
							// Low byte arrived first, so it sits in the low half.
							addr_r <= rx_nxt[ADDR_W-1:0];
							state_r <= ST_FETCH;
						end
					end
				end
				ST_FETCH: begin
					tx_r <= {8'hff, fetch_byte};
					cnt_r <= BITS_BYTE;
					state_r <= ST_BYTE;
				end
				ST_BYTE: begin
					if (slot.rd) begin
						tx_r <= {1'b1, tx_r[15:1]};
						cnt_r <= cnt_r - 5'h01;
					end
					if (last_bit) begin
						cnt_r <= BITS_CRC;
						if (redir_r || page_end) begin
							state_r <= ST_CRC;
						end else begin
							addr_r <= addr_r + 11'h001;
							state_r <= ST_FETCH;
						end
					end
				end
				ST_CRC: begin
					if (slot.rd) begin
						tx_r <= {1'b1, tx_r[15:1]};
						cnt_r <= cnt_r - 5'h01;
					end
					if (last_bit) begin
						if (redir_r) begin
							redir_r <= 1'b0;
							state_r <= ST_FETCH;
						end else if (addr_r == ADDR_LAST) begin
							state_r <= ST_ONES;
						end else begin
							// The next page opens at its first byte.
							addr_r <= addr_r + 11'h001;
							redir_r <= ext_r;
							state_r <= ST_FETCH;
						end
					end
				end
				ST_ONES: begin
					tx_r <= '1;
				end
				ST_IGNORE: begin
					tx_r <= '1;
				end
			endcase
			// The CRC is handed out the moment the last byte bit is gone.
			if (state_r == ST_BYTE && last_bit && (redir_r || page_end)) begin
				tx_r <= crc_r ^ CRC_OUT_XOR;
			end
		end
	end

	// -------------------------------------------------------------------
	// CRC generator
	// -------------------------------------------------------------------
	// A whole byte is folded in when fetched; a reset before it is sent
	// discards the CRC anyway, so early folding changes nothing visible.
	always_ff @(posedge clk) begin
		if (reset || bus_rst) begin
			crc_r <= CRC_CLEAR;
		end else if ((state_r == ST_CMD || state_r == ST_ADDR) && slot.wr) begin
			crc_r <= crc_step(crc_r, crc_in);
		end else if (state_r == ST_FETCH) begin
			crc_r <= crc_byte(crc_r, fetch_byte);
		end else if (state_r == ST_CRC && last_bit) begin
			crc_r <= CRC_CLEAR;
		end
	end

	// -------------------------------------------------------------------
	// Read slot answer
	// -------------------------------------------------------------------
	// Idle, address and trailing states answer with ones.
	always_ff @(posedge clk) begin
		if (reset || bus_rst) begin
			tx_bit <= 1'b1;
		end else if (state_r == ST_BYTE || state_r == ST_CRC) begin
			tx_bit <= tx_r[0];
		end else begin
			tx_bit <= 1'b1;
		end
	end

endmodule

// ### verif/rd_engine_checker.sv
// Purpose: Port level checks on the read engine.
// Assumes: One clock domain, reset synchronous and active high.
// Notes: Bound to every instance of the engine.
`timescale 1ns/1ps
module rd_engine_checker
	import rd_engine_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic bus_rst,
	input wire rd_engine_pkg::slot_t slot,
	input wire logic [7:0] mem_rdata,
	input wire rd_engine_pkg::mem_req_t mem_req,
	input wire logic tx_bit,
	input wire logic busy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	chk_reset_to_idle: assert property ($fell(reset) |-> !busy && tx_bit && !mem_req.en)
		else $error("engine not idle after reset");
	chk_abort_idle: assert property (bus_rst |=> !busy && tx_bit)
		else $error("bus reset did not abort");
	chk_abort_quiet: assert property (bus_rst |=> !mem_req.en [*3])
		else $error("fetch after bus reset");
	chk_fetch_pulse: assert property (mem_req.en |=> !mem_req.en)
		else $error("fetch longer than one cycle");
	chk_idle_ones: assert property (!busy |-> tx_bit)
		else $error("idle line not one");
	// A bit may only move after a read slot, a fetch or a bus reset.
	chk_tx_cause: assert property ($changed(tx_bit) |-> $past(slot.rd, 2) || $past(mem_req.en)
		|| $past(mem_req.en, 2) || $past(mem_req.en, 3) || $past(bus_rst)) else $error("tx bit moved");
	chk_fetch_busy: assert property (mem_req.en |-> busy)
		else $error("fetch while idle");
	chk_busy_holds: assert property (busy && !bus_rst |=> busy)
		else $error("sequence ended without reset");
endmodule

bind rd_engine rd_engine_checker chk_i (.clk(clk), .reset(reset), .bus_rst(bus_rst), .slot(slot),
	.mem_rdata(mem_rdata), .mem_req(mem_req), .tx_bit(tx_bit), .busy(busy));

// ### verif/mem_model.sv
// Purpose: Memory behind the read engine, answering in the request cycle.
// Assumes: Data byte is address xor 5ah, status byte address xor c3h.
// Notes: Outside a request it shows the inverse, so stale reads show up.
`timescale 1ns/1ps
module mem_model
	import rd_engine_pkg::*;
(
	input wire rd_engine_pkg::mem_req_t mem_req,
	output logic [7:0] mem_rdata
);
	logic [7:0] v;
	// Redirection bytes live at 100h plus page, like any other status byte.
	always_comb begin
		v = mem_req.addr[7:0] ^ (mem_req.status ? 8'hc3 : 8'h5a);
		mem_rdata = mem_req.en ? v : ~v;
	end
endmodule

// ### verif/testbench.sv
// Purpose: Self-checking bench acting as bus master for the read engine.
// Assumes: Slots four cycles apart; tx bit read in the strobe cycle.
// Notes: Expected bytes and CRCs are rebuilt here from the memory pattern.
`timescale 1ns/1ps
module testbench;
	import rd_engine_pkg::*;
	logic clk, reset, bus_rst, tx_bit, busy;
	slot_t slot;
	mem_req_t mem_req;
	logic [7:0] mem_rdata;
	int error_cnt, checked;
	rd_engine uut (.clk(clk), .reset(reset), .bus_rst(bus_rst), .slot(slot), .mem_rdata(mem_rdata),
		.mem_req(mem_req), .tx_bit(tx_bit), .busy(busy));
	mem_model mem (.mem_req(mem_req), .mem_rdata(mem_rdata));
	// Free running 40 MHz clock.
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	function automatic logic [15:0] cu(input logic [15:0] c, input logic [7:0] b);
		for (int i = 0; i < 8; i++) c = (c[0] ^ b[i]) ? (c >> 1) ^ CRC_POLY_REFL : c >> 1;
		return c;
	endfunction
	// Unimplemented status places must read blank whatever the memory says.
	function automatic logic [7:0] sb(input logic [10:0] a);
		if (a < 11'h008 || (a >= 11'h020 && a < 11'h028) || (a >= 11'h040 && a < 11'h048)
			|| (a >= REDIR_BASE && a <= REDIR_END)) return a[7:0] ^ 8'hc3;
		return BLANK_BYTE;
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One slot: strobe one cycle, then three quiet cycles to keep the spacing.
	task automatic slt(input logic w, input logic r, input logic b, output logic t);
		@(posedge clk);
		slot <= '{wr: w, wbit: b, rd: r};
		@(negedge clk);
		t = tx_bit;
		@(posedge clk);
		slot <= '0;
		repeat (2) @(posedge clk);
	endtask
	task automatic wb(input logic [7:0] b);
		logic t;
		for (int i = 0; i < 8; i++) slt(1'b1, 1'b0, b[i], t);
	endtask
	task automatic rb(output logic [7:0] b);
		for (int i = 0; i < 8; i++) slt(1'b0, 1'b1, 1'b0, b[i]);
	endtask
	task automatic cmd(input logic [7:0] c, input logic [15:0] a, output logic [15:0] crc);
		wb(c);
		wb(a[7:0]);
		wb(a[15:8]);
		crc = cu(cu(cu(CRC_CLEAR, c), a[7:0]), a[15:8]);
	endtask
	task automatic eb(input logic [7:0] e, inout logic [15:0] crc);
		logic [7:0] b;
		rb(b);
		chk({8'h00, b}, {8'h00, e});
		crc = cu(crc, e);
	endtask
	task automatic ec(input logic [15:0] crc);
		logic [15:0] c;
		rb(c[7:0]);
		rb(c[15:8]);
		chk(c, crc ^ CRC_OUT_XOR);
	endtask
	task automatic abort;
		@(posedge clk);
		bus_rst <= 1'b1;
		@(posedge clk);
		bus_rst <= 1'b0;
		@(negedge clk);
		chk({14'h0, busy, tx_bit}, 16'h0001);
	endtask
	task automatic status_read;
		logic [15:0] c;
		cmd(CMD_READ_STATUS, 16'h0006, c);
		eb(sb(11'h006), c);
		eb(sb(11'h007), c);
		ec(c);
		c = CRC_CLEAR;
		for (int a = 8; a < 16; a++) eb(sb(11'(a)), c);
		ec(c);
		abort();
	endtask
	task automatic ext_read;
		logic [15:0] c;
		cmd(CMD_EXT_READ, 16'h003e, c);
		eb(sb(11'h101), c);
		ec(c);
		c = CRC_CLEAR;
		eb(8'h3e ^ 8'h5a, c);
		eb(8'h3f ^ 8'h5a, c);
		ec(c);
		c = CRC_CLEAR;
		eb(sb(11'h102), c);
		ec(c);
		c = CRC_CLEAR;
		eb(8'h40 ^ 8'h5a, c);
		abort();
	endtask
	// Top address bits are dropped, so the read lands on the last page.
	task automatic high_addr;
		logic [15:0] c, m;
		cmd(CMD_EXT_READ, 16'hffff, m);
		// The engine folds in the address it kept, so its CRC differs from m.
		c = cu(cu(cu(CRC_CLEAR, CMD_EXT_READ), 8'hff), 8'h07);
		eb(sb(11'h13f), c);
		ec(c);
		c = CRC_CLEAR;
		eb(8'hff ^ 8'h5a, c);
		ec(c);
		eb(8'hff, c);
		abort();
		// The first CRC disagreed with the master's own, so it starts over.
		cmd(CMD_EXT_READ, 16'h07ff, c);
		eb(sb(11'h13f), c);
		ec(c);
		abort();
	endtask
	task automatic status_end;
		logic [15:0] c;
		cmd(CMD_READ_STATUS, 16'h07fe, c);
		eb(BLANK_BYTE, c);
		eb(BLANK_BYTE, c);
		ec(c);
		eb(8'hff, c);
		abort();
	endtask
	// Page zero points at page 3ch, whose own redirection byte says it is valid.
	task automatic redirect;
		logic [15:0] c;
		logic [7:0] r;
		cmd(CMD_EXT_READ, 16'h0005, c);
		rb(r);
		chk({8'h00, r}, {8'h00, sb(11'h100)});
		c = cu(c, sb(11'h100));
		ec(c);
		abort();
		cmd(CMD_EXT_READ, (r == 8'hff) ? 16'h0005 : {3'h0, ~r, 5'h00}, c);
		eb(8'hff, c);
		ec(c);
		c = CRC_CLEAR;
		eb(8'h80 ^ 8'h5a, c);
		abort();
	endtask
	// A code the engine does not serve leaves it idle, answering ones.
	task automatic unknown_cmd;
		logic [7:0] b;
		wb(8'h5a);
		rb(b);
		chk({7'h00, busy, b}, 16'h00ff);
		abort();
	endtask
	task automatic report_and_stop;
		if (error_cnt == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Reset for eight cycles, then each sequence in turn.
	initial begin
		error_cnt = 0;
		checked = 0;
		reset = 1'b1;
		bus_rst = 1'b0;
		slot = '0;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		status_read();
		ext_read();
		high_addr();
		status_end();
		redirect();
		unknown_cmd();
		report_and_stop();
	end
endmodule
